// [tap_controller.v]
`timescale 1ns/10ps
`include "tap_map.vh"
module tap_controller #(
  parameter [3:0]  VERSION   = 4'h1,        // Arbitrary value.
  parameter [15:0] PART_NUM  = 16'h1234,    // Arbitrary value.
  parameter [10:0] MAKER_ID  = 11'h055,     // Arbitrary value.
  parameter        BSCAN_LEN = 8,
  parameter        BUSY_CYC  = 64
) (
  // Clock and reset
  input  wire                 clk_sys_i,
  input  wire                 rst_i,
  input  wire                 ce_i,
  // Test port pins
  input  wire                 test_port_clock_i,
  input  wire                 mode_sel_i,
  input  wire                 tdi_i,
  input  wire                 trst_n_i,
  output reg                  tdo_o,
  output reg                  tdo_oe_o,
  // Boundary and functional side
  input  wire [BSCAN_LEN-1:0] pins_in_i,
  output wire [BSCAN_LEN-1:0] pins_out_o,
  output wire                 pins_force_o,
  output wire                 pins_highz_o,
  output wire                 test_active_o,
  // Configuration registers
  output reg  [95:0]          cfg_o,
  output wire                 cfg_save_o,
  output wire                 cfg_restore_o,
  input  wire [95:0]          nvm_data_i,
  output wire                 busy_o,
  output wire [3:0]           instr_bits_o
);
  reg  [2:0]  tck_s;
  reg  [1:0]  tms_s;
  reg  [1:0]  tdi_s;
  reg  [1:0]  trst_s;
  wire        rise = tck_s[1] & ~tck_s[2];
  wire        fall = ~tck_s[1] & tck_s[2];
  wire [3:0]  state;
  reg  [3:0]  ir_shift;
  reg  [3:0]  instr_bits;
  reg         bypass_bit;
  reg  [31:0] ident_sh;
  reg  [BSCAN_LEN-1:0] bscan_sh;
  reg  [BSCAN_LEN-1:0] bscan_upd;
  reg  [`CFG_LEN-1:0]  cfg_sh;
  reg  [15:0] busy_cnt;
  reg         save_p;
  reg         rest_p;
  wire [31:0] ident_word = {VERSION, PART_NUM, MAKER_ID, 1'b1};
  wire        busy = (busy_cnt != 16'h0000);

  function [1:0] select_reg;
    input [3:0] code;
    input       b;
    begin
      case (code)
        `INS_EXTEST, `INS_SAMPLE: select_reg = `SEL_BSCAN;
        `INS_IDCODE:              select_reg = `SEL_IDENT;
        `INS_CFG_WR, `INS_CFG_RD: select_reg = b ? `SEL_BYPASS : `SEL_CFG;
        default:                  select_reg = `SEL_BYPASS;
      endcase
    end
  endfunction

  wire [1:0] sel = select_reg(instr_bits, busy);

  // Pins cross from the test host's domain through two flops each; the test clock has a third flop for edge detection.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tck_s  <= 3'h0;
      tms_s  <= 2'h3;
      tdi_s  <= 2'h3;
      trst_s <= 2'h3;
    end else if (ce_i) begin
      tck_s  <= {tck_s[1:0], test_port_clock_i};
      tms_s  <= {tms_s[0], mode_sel_i};
      tdi_s  <= {tdi_s[0], tdi_i};
      trst_s <= {trst_s[0], trst_n_i};
    end
  end

  tap_fsm u_fsm (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .step_i     (rise),
    .mode_sel_i (tms_s[1]),
    .trst_n_i   (trst_s[1]),
    .state_o    (state)
  );

  // Rising edge work: capture and shift.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ir_shift   <= 4'h0;
      bypass_bit <= 1'b0;
      ident_sh   <= 32'h0000_0000;
      bscan_sh   <= {BSCAN_LEN{1'b0}};
      cfg_sh     <= {`CFG_LEN{1'b0}};
    end else if (ce_i && rise) begin
      case (state)
        `ST_CAP_IR: ir_shift <= `IR_CAPTURE;
        `ST_SH_IR:  ir_shift <= {tdi_s[1], ir_shift[3:1]};
        `ST_CAP_DR: begin
          bypass_bit <= 1'b0;
          if (sel == `SEL_IDENT) ident_sh <= ident_word;
          if (sel == `SEL_BSCAN) bscan_sh <= pins_in_i;
          if (sel == `SEL_CFG)   cfg_sh   <= {16'h0000, cfg_o};
        end
        `ST_SH_DR: begin
          case (sel)
            `SEL_BYPASS: bypass_bit <= tdi_s[1];
            `SEL_IDENT:  ident_sh   <= {tdi_s[1], ident_sh[31:1]};
            `SEL_BSCAN:  bscan_sh   <= {tdi_s[1], bscan_sh[BSCAN_LEN-1:1]};
            default:     cfg_sh     <= {tdi_s[1], cfg_sh[`CFG_LEN-1:1]};
          endcase
        end
        default: ir_shift <= ir_shift;
      endcase
    end
  end

  // Falling edge work: update latches and serial out; the reset state and a restore load act in any cycle.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      instr_bits <= `INS_IDCODE;
      bscan_upd  <= {BSCAN_LEN{1'b0}};
      cfg_o      <= 96'h0;
      tdo_o      <= 1'b1;
      tdo_oe_o   <= 1'b0;
    end else if (ce_i) begin
      if (state == `ST_RESET) begin
        instr_bits <= `INS_IDCODE;
      end else if (fall) begin
        if (state == `ST_UPD_IR) instr_bits <= ir_shift;
        if (state == `ST_UPD_DR && sel == `SEL_BSCAN) bscan_upd <= bscan_sh;
        // The reserved stages sit nearest the serial input, so the data ends at the bottom.
        if (state == `ST_UPD_DR && sel == `SEL_CFG && instr_bits == `INS_CFG_WR)
          cfg_o <= cfg_sh[`CFG_DATA_LEN-1:0];
      end
      if (rest_p) cfg_o <= nvm_data_i;
      if (fall) begin
        tdo_oe_o <= (state == `ST_SH_IR) || (state == `ST_SH_DR);
        if (state == `ST_SH_IR) tdo_o <= ir_shift[0];
        else case (sel)
          `SEL_BYPASS: tdo_o <= bypass_bit;
          `SEL_IDENT:  tdo_o <= ident_sh[0];
          `SEL_BSCAN:  tdo_o <= bscan_sh[0];
          default:     tdo_o <= cfg_sh[0];
        endcase
      end
    end
  end

  // Save and restore start on entry to idle; the busy window blocks new ones.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      busy_cnt <= 16'h0000;
      save_p   <= 1'b0;
      rest_p   <= 1'b0;
    end else if (ce_i) begin
      save_p <= 1'b0;
      rest_p <= 1'b0;
      if (busy) begin
        busy_cnt <= busy_cnt - 16'h0001;
      end else if (rise && state == `ST_UPD_IR && tms_s[1] == 1'b0) begin
        if (ir_shift == `INS_CFG_SAVE || ir_shift == `INS_CFG_REST) begin
          busy_cnt <= BUSY_CYC[15:0];
          save_p   <= (ir_shift == `INS_CFG_SAVE);
          rest_p   <= (ir_shift == `INS_CFG_REST);
        end
      end
    end
  end

  assign pins_out_o    = bscan_upd;
  assign pins_force_o  = (instr_bits == `INS_EXTEST) || (instr_bits == `INS_CLAMP);
  assign pins_highz_o  = (instr_bits == `INS_HIGHZ);
  assign test_active_o = pins_force_o | pins_highz_o;
  assign cfg_save_o    = save_p;
  assign cfg_restore_o = rest_p;
  assign busy_o        = busy;
  assign instr_bits_o  = instr_bits;
endmodule

// [tap_map.vh]
// How it works
// - Five clocks with mode-select high reset controller.
// - State changes on rising test clock edge.
// - Reset state disables all test logic.
// - Idle state acts only for active instructions.
// - Instruction capture loads pattern ending 01.
// - Instruction shift moves bits through register.
// - Instruction pause holds shift contents.
// - Instruction update latches on falling edge.
// - Data capture loads the selected register.
// - Data path states mirror instruction path.
// - Instruction register four bits, LSB out first.
// - Decode boundary scan, sample and identity codes.
// - Decode configuration write, read, save, restore.
// - Decode clamp, high-z; others act as bypass.
// - Bypass stage captures zero.
// - Bypass shifting leaves function untouched.
// - Identity word is read-only 32 bits.
// - Identity word field layout, bit 0 one.
// - Shared serial path, instruction selects register.
// - Boundary test drives outputs, captures inputs.
// - Instruction select may return to reset.
// - Configuration path 112 stages, top 16 read-only.
// - Save or restore busy ignores programming instructions.
// - Identity selected after any reset.
`ifndef TAP_MAP_VH
`define TAP_MAP_VH
`define ST_RESET      4'h0
`define ST_IDLE       4'h1
`define ST_SEL_DR     4'h2
`define ST_CAP_DR     4'h3
`define ST_SH_DR      4'h4
`define ST_EX1_DR     4'h5
`define ST_PAU_DR     4'h6
`define ST_EX2_DR     4'h7
`define ST_UPD_DR     4'h8
`define ST_SEL_IR     4'h9
`define ST_CAP_IR     4'ha
`define ST_SH_IR      4'hb
`define ST_EX1_IR     4'hc
`define ST_PAU_IR     4'hd
`define ST_EX2_IR     4'he
`define ST_UPD_IR     4'hf
`define INS_EXTEST    4'h0
`define INS_SAMPLE    4'h1
`define INS_IDCODE    4'h2
`define INS_CFG_WR    4'h4
`define INS_CFG_RD    4'h5
`define INS_CFG_SAVE  4'h6
`define INS_CFG_REST  4'h7
`define INS_CLAMP     4'h8
`define INS_HIGHZ     4'h9
`define INS_BYPASS    4'hf
`define IR_CAPTURE    4'h1
`define SEL_BYPASS    2'h0
`define SEL_BSCAN     2'h1
`define SEL_IDENT     2'h2
`define SEL_CFG       2'h3
`define CFG_LEN       112
`define CFG_DATA_LEN  96
`endif

// [tap_fsm.v]
`timescale 1ns/10ps
`include "tap_map.vh"
module tap_fsm (
  // Clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       ce_i,
  // Stepping
  input  wire       step_i,
  input  wire       mode_sel_i,
  input  wire       trst_n_i,
  // State
  output reg  [3:0] state_o
);
  reg [3:0] next_state;
  always @* begin
    case (state_o)
      `ST_RESET:  next_state = mode_sel_i ? `ST_RESET  : `ST_IDLE;
      `ST_IDLE:   next_state = mode_sel_i ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_DR: next_state = mode_sel_i ? `ST_SEL_IR : `ST_CAP_DR;
      `ST_CAP_DR: next_state = mode_sel_i ? `ST_EX1_DR : `ST_SH_DR;
      `ST_SH_DR:  next_state = mode_sel_i ? `ST_EX1_DR : `ST_SH_DR;
      `ST_EX1_DR: next_state = mode_sel_i ? `ST_UPD_DR : `ST_PAU_DR;
      `ST_PAU_DR: next_state = mode_sel_i ? `ST_EX2_DR : `ST_PAU_DR;
      `ST_EX2_DR: next_state = mode_sel_i ? `ST_UPD_DR : `ST_SH_DR;
      `ST_UPD_DR: next_state = mode_sel_i ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_IR: next_state = mode_sel_i ? `ST_RESET  : `ST_CAP_IR;
      `ST_CAP_IR: next_state = mode_sel_i ? `ST_EX1_IR : `ST_SH_IR;
      `ST_SH_IR:  next_state = mode_sel_i ? `ST_EX1_IR : `ST_SH_IR;
      `ST_EX1_IR: next_state = mode_sel_i ? `ST_UPD_IR : `ST_PAU_IR;
      `ST_PAU_IR: next_state = mode_sel_i ? `ST_EX2_IR : `ST_PAU_IR;
      `ST_EX2_IR: next_state = mode_sel_i ? `ST_UPD_IR : `ST_SH_IR;
      `ST_UPD_IR: next_state = mode_sel_i ? `ST_SEL_DR : `ST_IDLE;
      default:    next_state = `ST_RESET;
    endcase
  end
  // The test reset is already synchronised, so acting on it at once in the clock
  // domain is the closest a sampled design gets to asynchronous behaviour.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_o <= `ST_RESET;
    end else if (ce_i) begin
      if (!trst_n_i) begin
        state_o <= `ST_RESET;
      end else if (step_i) begin
        state_o <= next_state;
      end
    end
  end
endmodule

// [tap_sva.sv]
`timescale 1ns/10ps
`include "tap_map.vh"
module tap_sva #(
  parameter BUSY_CYC = 64
) (
  input wire        clk_sys_i, rst_i, test_port_clock_i, tdo_o, tdo_oe_o,
  input wire        pins_force_o, pins_highz_o, test_active_o, busy_o,
  input wire        cfg_save_o, cfg_restore_o,
  input wire [95:0] cfg_o, nvm_data_i,
  input wire [3:0]  instr_bits_o
);
  localparam int BMAX = BUSY_CYC + 4;
  reg       tck_q;
  reg [3:0] since_fall;
  // Pin-side outputs may only move shortly after a test clock fall; only the return to the identity instruction on reset may follow a rise.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tck_q      <= 1'b0;
      since_fall <= 4'hf;
    end else begin
      tck_q <= test_port_clock_i;
      if (tck_q && !test_port_clock_i)
        since_fall <= 4'h0;
      else if (since_fall != 4'hf)
        since_fall <= since_fall + 4'h1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_force; pins_force_o == (instr_bits_o == 4'h0 || instr_bits_o == 4'h8); endproperty
  a_force: assert property (p_force) else $error("force flag wrong");
  property p_act; test_active_o == (pins_force_o || pins_highz_o) && pins_highz_o ==
    (instr_bits_o == `INS_HIGHZ); endproperty
  a_act: assert property (p_act) else $error("active flag wrong");
  property p_tdo; !$stable(tdo_oe_o) || (tdo_oe_o && !$stable(tdo_o)) |-> since_fall < 6;
  endproperty
  a_tdo: assert property (p_tdo) else $error("serial out moved off the fall");
  property p_ins; !$stable(instr_bits_o) && instr_bits_o != `INS_IDCODE |-> since_fall < 6;
  endproperty
  a_ins: assert property (p_ins) else $error("instruction moved off the fall");
  property p_save; cfg_save_o |-> instr_bits_o == 4'h6 ##1 !cfg_save_o ##[0:2] busy_o;
  endproperty
  a_save: assert property (p_save) else $error("save pulse wrong");
  property p_rest; cfg_restore_o |-> ##[1:2] cfg_o == nvm_data_i; endproperty
  a_rest: assert property (p_rest) else $error("restore not loaded");
  property p_busy; $rose(busy_o) |-> busy_o [*8] ##[1:BMAX] !busy_o; endproperty
  a_busy: assert property (p_busy) else $error("busy length wrong");
  property p_rst; disable iff (1'b0) rst_i |-> !tdo_oe_o && cfg_o == 96'h0 &&
    instr_bits_o == `INS_IDCODE; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  c_save: cover property (cfg_save_o);
  c_rest: cover property (cfg_restore_o);
  c_oe: cover property ($rose(tdo_oe_o));
endmodule
bind tap_controller tap_sva #(.BUSY_CYC(BUSY_CYC)) chk (
  .clk_sys_i         (clk_sys_i),
  .rst_i             (rst_i),
  .test_port_clock_i (test_port_clock_i),
  .tdo_o             (tdo_o),
  .tdo_oe_o          (tdo_oe_o),
  .pins_force_o      (pins_force_o),
  .pins_highz_o      (pins_highz_o),
  .test_active_o     (test_active_o),
  .busy_o            (busy_o),
  .cfg_save_o        (cfg_save_o),
  .cfg_restore_o     (cfg_restore_o),
  .cfg_o             (cfg_o),
  .nvm_data_i        (nvm_data_i),
  .instr_bits_o      (instr_bits_o)
);

// [tap_host.sv]
`timescale 1ns/10ps
module tap_host (
  // Clock
  input  wire clk_sys_i,
  // Scan pins
  input  wire tdo_i,
  input  wire tdo_oe_i,
  output reg  tck_o = 1'b0,
  output reg  tms_o = 1'b1,
  output reg  tdi_o = 1'b0
);
  reg last = 1'b0;
  // One 800 ns period: drive on the fall, device samples on the rise.
  task step(input m, input d, output b);
    @(posedge clk_sys_i);
    {tck_o, tms_o, tdi_o} <= {1'b0, m, d};
    repeat (4) @(posedge clk_sys_i);
    tck_o <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    // An undriven line has no keeper, so its old bit must never read as valid.
    b = tdo_oe_i ? tdo_i : ~last;
    last = b;
  endtask
  task seq(input int n, input [127:0] m, input [127:0] d, output [127:0] o);
    int i;
    o = '0;
    for (i = 0; i < n; i++)
      step(m[i], d[i], o[i]);
  endtask
  // Idle to shift, n bits LSB first, then update and back to idle.
  task scan(input [3:0] pre, input int k, input int n, input [127:0] d,
            output [127:0] o);
    reg [127:0] t;
    seq(k, pre, 0, t);
    seq(n, 128'h1 << (n - 1), d, o);
    seq(2, 1, 0, t);
  endtask
endmodule

// [tap_controller_bench.sv]
`timescale 1ns/10ps
`include "tap_map.vh"
module tap_controller_bench;
  localparam [95:0] NVM = 96'h0123_4567_89ab_cdef_0f1e_2d3c;
  localparam [31:0] ID  = {4'h1, 16'h1234, 11'h055, 1'b1};
  reg          clk_sys_i, rst_i = 1'b0, trst_n_i = 1'b1;
  wire         test_port_clock_i, mode_sel_i, tdi_i, tdo_o, tdo_oe_o, pins_force_o;
  wire         pins_highz_o, test_active_o, cfg_save_o, cfg_restore_o, busy_o;
  wire         ce_i = 1'b1;
  wire [7:0]   pins_in_i = 8'h5a;
  wire [7:0]   pins_out_o;
  wire [95:0]  nvm_data_i = NVM;
  wire [95:0]  cfg_o;
  wire [3:0]   instr_bits_o;
  reg  [127:0] o, t;
  int          mismatches = 0, num_checks = 0;
  tap_controller #(.BUSY_CYC(400)) uut (
    .clk_sys_i         (clk_sys_i),
    .rst_i             (rst_i),
    .ce_i              (ce_i),
    .test_port_clock_i (test_port_clock_i),
    .mode_sel_i        (mode_sel_i),
    .tdi_i             (tdi_i),
    .trst_n_i          (trst_n_i),
    .tdo_o             (tdo_o),
    .tdo_oe_o          (tdo_oe_o),
    .pins_in_i         (pins_in_i),
    .pins_out_o        (pins_out_o),
    .pins_force_o      (pins_force_o),
    .pins_highz_o      (pins_highz_o),
    .test_active_o     (test_active_o),
    .cfg_o             (cfg_o),
    .cfg_save_o        (cfg_save_o),
    .cfg_restore_o     (cfg_restore_o),
    .nvm_data_i        (nvm_data_i),
    .busy_o            (busy_o),
    .instr_bits_o      (instr_bits_o)
  );
  tap_host host (.clk_sys_i(clk_sys_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o),
                 .tck_o(test_port_clock_i), .tms_o(mode_sel_i), .tdi_o(tdi_i));
  task chk(input string nm, input [127:0] e, input [127:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task t_reset;
    host.seq(6, 8'h1f, 0, t);
    chk("instr", `INS_IDCODE, instr_bits_o);
    host.seq(3, 1, 0, t);
    host.seq(16, 16'h8000, 0, o);
    host.seq(4, 4'h4, 0, t);
    host.seq(16, 16'h8000, 0, t);
    chk("idword", ID, {t[15:0], o[15:0]});
    host.seq(2, 1, 0, t);
    host.scan(4'h3, 4, 4, 4'hf, o);
    host.seq(6, 8'h1f, 0, t);
    chk("tms reset", `INS_IDCODE, instr_bits_o);
    host.scan(4'h3, 4, 4, 4'hf, o);
    trst_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    trst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk("trst", `INS_IDCODE, instr_bits_o);
    host.seq(1, 0, 0, t);
  endtask
  task t_decode;
    reg [127:0] e;
    int c, k;
    for (c = 0; c < 16; c++) begin
      host.scan(4'h3, 4, 4, c, o);
      chk("capture", 2'b01, o[1:0]);
      chk("instr", c, instr_bits_o);
      chk("force", c == 0 || c == 8, pins_force_o);
      chk("highz", c == 9, pins_highz_o);
      host.scan(4'h1, 3, 33, {128{1'b1}}, o);
      e = {95'h0, 33'h1_ffff_fffe};
      if (c < 2)
        e = {95'h0, 25'h1ff_ffff, 8'h5a};
      if (c == 2)
        e = {95'h0, 1'b1, ID};
      // Configuration starts clear, and the ones of the write scan land only in its top bits.
      if (c == 4 || c == 5)
        e = 128'h0;
      chk("path", e, o);
      if (c < 2)
        chk("pins out", 8'hff, pins_out_o);
      for (k = 0; k < 500 && busy_o !== 1'b0; k++)
        @(posedge clk_sys_i);
    end
    chk("restored", NVM, cfg_o);
  endtask
  task t_cfg;
    reg [127:0] d = {16'hffff, 96'hfedc_ba98_7654_3210_a5a5_c3c3};
    host.scan(4'h3, 4, 4, `INS_CFG_WR, o);
    host.scan(4'h1, 3, 112, d, o);
    chk("cfg", d[95:0], cfg_o);
    host.scan(4'h3, 4, 4, `INS_CFG_RD, o);
    host.scan(4'h1, 3, 112, 0, o);
    chk("readback", d[95:0], o);
    host.scan(4'h3, 4, 4, `INS_CFG_SAVE, o);
    repeat (4) @(posedge clk_sys_i);
    chk("busy", 1, busy_o);
    host.scan(4'h3, 4, 4, `INS_CFG_RD, o);
    host.scan(4'h1, 3, 2, 2'b11, o);
    chk("refused", 2'b10, o);
  endtask
  task final_report;
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // The full sequence needs about 9200 cycles.
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    mismatches++;
    final_report;
  end
  initial begin
    // A non-blocking rise at time zero gives the design a real reset edge.
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset;
    t_decode;
    t_cfg;
    final_report;
  end
endmodule
